// ### rtl/pwmcc_top.sv
// PWM clock generation, channel clock selection, join control and pin takeover
//
// Overview of operation
// - Join bit high pairs channels 2,3 as 16 bits, channel 2 upper byte.
// - Joined pair 2/3 drives pin 2, clocks from channel 3 select, frees pin 3.
// - Join bit low pairs 0,1: pin 0 drives, channel 1 select clocks, pin 1 freed.
// - Clock A, three-bit divide field, feeds only channels 0 and 1.
// - Clock B, own three-bit divide field, feeds only channels 2 and 3.
// - Divide code n gives input clock over two to the n; zero passes it.
// - Channels 2,3: select clear takes clock B, set takes scaled clock one.
// - Channels 0,1: select clear takes clock A, set takes scaled clock zero.
// - Changing a select while running may give one odd pulse; no glitch guard.
// - Polarity clear starts period low, rises at duty; set starts high, falls.
// - Duty counts low time with polarity clear, high time with it set.
// - Channel enable forces pin to output unless a join frees it, direction bit untouched, restored after.
// - Selected clock reaches channel only while enabled, gated on tick edges.
// - Prescale counter stops while all four enables are clear.
// - Waveform reaches pin when channel clock begins its next cycle after enable.
// - Prescale counter: free-running seven bits, readable, special-mode writable, top zero.
// - Scale zero write loads scaler counter zero unless special mode inhibits it.
// - Scaled clock zero is clock A over scale zero plus one, then halved.
// - Scaled clock one is clock B over scale one plus one, then halved.
// - Scaler counters count down, reload from scale value at zero, readable.
`timescale 1ns/100ps
`default_nettype none
module pwmcc_top (
	input  wire logic                   sys_clk,
	input  wire logic                   reset,
	input  wire pwmcc_pkg::pwmcc_bus_s  bus_req,
	output logic [7:0]                  rd_data,
	input  wire logic                   special_mode_flag,
	input  wire logic [3:0]             port_direction_bits,
	input  wire logic [3:0]             port_gpio_data,
	input  wire logic [3:0]             chan_period_start,
	input  wire logic [3:0]             chan_duty_match,
	output logic [3:0]                  chan_clk_tick,
	output logic                        join_pair_low,
	output logic                        join_pair_high,
	output logic [3:0]                  pin_out,
	output logic [3:0]                  pin_oe_n
);
	import pwmcc_pkg::*;

	// ==========================================================
	// Register state
	logic       join_high_reg;
	logic       join_low_reg;
	logic [2:0] clock_a_divide_field_reg;
	logic [2:0] clock_b_divide_field_reg;
	logic [3:0] scaled_select_reg;
	logic [3:0] start_high_reg;
	logic [3:0] chan_on_reg;
	logic [6:0] presc_reg;
	logic [7:0] scale_zero_reg;
	logic [7:0] scale_one_reg;
	logic [7:0] scnt_zero_reg;
	logic [7:0] scnt_one_reg;
	logic       half_zero_reg;
	logic       half_one_reg;
	logic       load_inhibit_reg;
	logic       special_mode_flag_meta_reg;
	logic       special_mode_flag_reg;
	logic [7:0] rd_data_reg;
	logic [3:0] tick_reg;
	logic [3:0] started_reg;
	logic [3:0] wave_reg;
	logic [3:0] pin_out_reg;
	logic [3:0] pin_oe_n_reg;

	// ==========================================================
	// Address decode
	wire wr_ctrl   = bus_req.wr && (bus_req.addr == OFS_CLOCK_CTRL);
	wire wr_selpol = bus_req.wr && (bus_req.addr == OFS_SEL_POL);
	wire wr_en     = bus_req.wr && (bus_req.addr == OFS_CHAN_ENABLE);
	wire wr_presc  = bus_req.wr && (bus_req.addr == OFS_PRESCALE);
	wire wr_scal0  = bus_req.wr && (bus_req.addr == OFS_SCALE_ZERO);
	wire wr_scal1  = bus_req.wr && (bus_req.addr == OFS_SCALE_ONE);
	wire wr_test   = bus_req.wr && (bus_req.addr == OFS_TEST_CTRL);
	wire load_ok   = !(special_mode_flag_reg && load_inhibit_reg);

	// ==========================================================
	// Prescaler taps
	// run only while any channel is on
	wire       presc_run = |chan_on_reg;
	wire [6:0] mask_a    = 7'((8'h01 << clock_a_divide_field_reg) - 8'h01);
	wire [6:0] mask_b    = 7'((8'h01 << clock_b_divide_field_reg) - 8'h01);
	// tick when the low n bits are all ones
	wire       tick_a    = presc_run && ((presc_reg & mask_a) == mask_a);
	wire       tick_b    = presc_run && ((presc_reg & mask_b) == mask_b);

	// ==========================================================
	// Scalers: reload at zero, halve on reload
	wire       reload0 = tick_a && (scnt_zero_reg == RST_BYTE);
	wire       reload1 = tick_b && (scnt_one_reg == RST_BYTE);
	wire       tick_s0 = reload0 && half_zero_reg;
	wire       tick_s1 = reload1 && half_one_reg;
	wire [7:0] scnt0_next = wr_scal0 && load_ok ? bus_req.wdata :
		reload0 ? scale_zero_reg : tick_a ? scnt_zero_reg - 8'h01 : scnt_zero_reg;
	wire [7:0] scnt1_next = wr_scal1 && load_ok ? bus_req.wdata :
		reload1 ? scale_one_reg : tick_b ? scnt_one_reg - 8'h01 : scnt_one_reg;

	// ==========================================================
	// Per-channel clock selection and pin logic
	logic [3:0] tick_next;
	logic [3:0] drive_pin;
	logic [3:0] pin_out_next;
	logic [3:0] wave_next;
	logic [3:0] started_next;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
			// joined pair follows the lower-byte channel select
			wire sel_src = (gi == 0 && join_low_reg) ? scaled_select_reg[1] :
				(gi == 2 && join_high_reg) ? scaled_select_reg[3] : scaled_select_reg[gi];
			// source by channel group; no switch guard
			wire src_tick = (gi < 2) ? (sel_src ? tick_s0 : tick_a) :
				(sel_src ? tick_s1 : tick_b);
			assign tick_next[gi] = src_tick && chan_on_reg[gi];
			// start on the first tick after enable
			assign started_next[gi] = chan_on_reg[gi] && (started_reg[gi] || src_tick);
			// period starts at polarity level, duty flips it
			assign wave_next[gi] = !chan_on_reg[gi] ? start_high_reg[gi] :
				chan_period_start[gi] ? start_high_reg[gi] :
				chan_duty_match[gi] ? !start_high_reg[gi] : wave_reg[gi];
			// lower-byte pin of a joined pair is released
			wire freed = (gi == 1 && join_low_reg) || (gi == 3 && join_high_reg);
			// enable forces output without touching direction
			assign drive_pin[gi] = chan_on_reg[gi] && !freed;
			assign pin_out_next[gi] = (drive_pin[gi] && started_reg[gi]) ?
				wave_reg[gi] : port_gpio_data[gi];
		end
	endgenerate

	// ==========================================================
	// Read mux
	logic [7:0] rd_mux;
	always_comb begin
		unique case (bus_req.addr)
			OFS_CLOCK_CTRL:  rd_mux = {join_high_reg, join_low_reg,
				clock_a_divide_field_reg, clock_b_divide_field_reg};
			OFS_SEL_POL:     rd_mux = {scaled_select_reg, start_high_reg};
			OFS_CHAN_ENABLE: rd_mux = {RST_NIBBLE, chan_on_reg};
			OFS_PRESCALE:    rd_mux = {1'b0, presc_reg};
			OFS_SCALE_ZERO:  rd_mux = scale_zero_reg;
			OFS_SCNT_ZERO:   rd_mux = scnt_zero_reg;
			OFS_SCALE_ONE:   rd_mux = scale_one_reg;
			OFS_SCNT_ONE:    rd_mux = scnt_one_reg;
			OFS_TEST_CTRL:   rd_mux = 8'(load_inhibit_reg) << POS_LOAD_INHIB;
			default:         rd_mux = RST_BYTE;
		endcase
	end

	// ==========================================================
	// Special mode flag synchroniser
	always_ff @(posedge sys_clk) begin
		special_mode_flag_meta_reg <= reset ? 1'b0 : special_mode_flag;
		special_mode_flag_reg      <= reset ? 1'b0 : special_mode_flag_meta_reg;
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			join_high_reg            <= 1'b0;
			join_low_reg             <= 1'b0;
			clock_a_divide_field_reg <= RST_DIV;
			clock_b_divide_field_reg <= RST_DIV;
			scaled_select_reg        <= RST_NIBBLE;
			start_high_reg           <= RST_NIBBLE;
			chan_on_reg              <= RST_NIBBLE;
			scale_zero_reg           <= RST_BYTE;
			scale_one_reg            <= RST_BYTE;
			load_inhibit_reg         <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				join_high_reg            <= bus_req.wdata[POS_JOIN_HIGH];
				join_low_reg             <= bus_req.wdata[POS_JOIN_LOW];
				clock_a_divide_field_reg <= bus_req.wdata[POS_CLKA_LSB +: 3];
				clock_b_divide_field_reg <= bus_req.wdata[POS_CLKB_LSB +: 3];
			end
			if (wr_selpol) begin
				scaled_select_reg <= bus_req.wdata[POS_SEL_LSB +: 4];
				start_high_reg    <= bus_req.wdata[POS_POL_LSB +: 4];
			end
			if (wr_en) begin
				chan_on_reg <= bus_req.wdata[3:0];
			end
			if (wr_scal0) begin
				scale_zero_reg <= bus_req.wdata;
			end
			if (wr_scal1) begin
				scale_one_reg <= bus_req.wdata;
			end
			// Test bit writable in special mode, cleared in normal mode
			if (!special_mode_flag_reg) begin
				load_inhibit_reg <= 1'b0;
			end else if (wr_test) begin
				load_inhibit_reg <= bus_req.wdata[POS_LOAD_INHIB];
			end
		end
	end

	// ==========================================================
	// Prescale counter and scalers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			presc_reg     <= RST_PRESC;
			scnt_zero_reg <= RST_BYTE;
			scnt_one_reg  <= RST_BYTE;
			half_zero_reg <= 1'b0;
			half_one_reg  <= 1'b0;
		end else begin
			// writable only in special mode, else advances while any channel is on
			if (wr_presc && special_mode_flag_reg) begin
				presc_reg <= bus_req.wdata[6:0];
			end else if (presc_run) begin
				presc_reg <= presc_reg + 7'h01;
			end
			scnt_zero_reg <= scnt0_next;
			scnt_one_reg  <= scnt1_next;
			half_zero_reg <= half_zero_reg ^ reload0;
			half_one_reg  <= half_one_reg ^ reload1;
		end
	end

	// ==========================================================
	// Channel ticks, waveform levels, pins and read data
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tick_reg     <= RST_NIBBLE;
			started_reg  <= RST_NIBBLE;
			wave_reg     <= RST_NIBBLE;
			pin_out_reg  <= RST_NIBBLE;
			pin_oe_n_reg <= ~RST_NIBBLE;
			rd_data_reg  <= RST_BYTE;
		end else begin
			tick_reg     <= tick_next;
			started_reg  <= started_next;
			wave_reg     <= wave_next;
			pin_out_reg  <= pin_out_next;
			// Active-low enable: driven when forced or direction says output
			pin_oe_n_reg <= ~(drive_pin | port_direction_bits);
			rd_data_reg  <= bus_req.rd ? rd_mux : RST_BYTE;
		end
	end

	assign chan_clk_tick  = tick_reg;
	assign join_pair_low  = join_low_reg;
	assign join_pair_high = join_high_reg;
	assign pin_out        = pin_out_reg;
	assign pin_oe_n       = pin_oe_n_reg;
	assign rd_data        = rd_data_reg;

	// ==========================================================
	// Assertions
	prescale_stop_a: assert property (@(posedge sys_clk) disable iff (reset)
		(!presc_run && !wr_presc) |=> $stable(presc_reg))
		else $error("prescaler moved while all channels off");
	prescale_top_a: assert property (@(posedge sys_clk) disable iff (reset)
		(bus_req.rd && bus_req.addr == OFS_PRESCALE) |=> !rd_data[7])
		else $error("prescale top bit read as one");
	prescale_ro_a: assert property (@(posedge sys_clk) disable iff (reset)
		(wr_presc && !special_mode_flag_reg && !presc_run) |=> $stable(presc_reg))
		else $error("prescale written outside special mode");
	scale_load_a: assert property (@(posedge sys_clk) disable iff (reset)
		(wr_scal0 && load_ok) |=> scnt_zero_reg == $past(bus_req.wdata))
		else $error("scale write did not load scaler");
	tick_gate_a: assert property (@(posedge sys_clk) disable iff (reset)
		chan_clk_tick[2] |-> $past(chan_on_reg[2]))
		else $error("tick passed to disabled channel");
	force_out_a: assert property (@(posedge sys_clk) disable iff (reset)
		(chan_on_reg[0] && !wr_en) |=> !pin_oe_n[0])
		else $error("enabled pin not driven");
	release_low_a: assert property (@(posedge sys_clk) disable iff (reset)
		(join_low_reg && !wr_ctrl) |=> pin_oe_n[1] == !$past(port_direction_bits[1]))
		else $error("pin 1 not released when joined");
	release_high_a: assert property (@(posedge sys_clk) disable iff (reset)
		(join_high_reg && !wr_ctrl) |=> pin_oe_n[3] == !$past(port_direction_bits[3]))
		else $error("pin 3 not released when joined");
	clock_a_rate_a: assert property (@(posedge sys_clk) disable iff (reset)
		(tick_a && clock_a_divide_field_reg == 3'h1 && !wr_ctrl && !wr_presc) |=> !tick_a)
		else $error("clock A ticked too often");
	polarity_a: assert property (@(posedge sys_clk) disable iff (reset)
		(chan_on_reg[0] && chan_period_start[0]) |=> wave_reg[0] == $past(start_high_reg[0]))
		else $error("period did not start at polarity level");
	scaled_half_a: assert property (@(posedge sys_clk) disable iff (reset)
		tick_s0 |=> !half_zero_reg && !tick_s0)
		else $error("scaled clock zero not halved");
	tick_gate_low_a: assert property (@(posedge sys_clk) disable iff (reset)
		chan_clk_tick[0] |-> $past(chan_on_reg[0]))
		else $error("tick passed to disabled channel zero");
	join_clk_low_a: assert property (@(posedge sys_clk) disable iff (reset)
		(join_low_reg && chan_on_reg[0] && scaled_select_reg[1])
			|=> chan_clk_tick[0] == $past(tick_s0))
		else $error("joined low pair ignored channel one select");
	join_clk_high_a: assert property (@(posedge sys_clk) disable iff (reset)
		(join_high_reg && chan_on_reg[2] && !scaled_select_reg[3])
			|=> chan_clk_tick[2] == $past(tick_b))
		else $error("joined high pair ignored channel three select");
	scaled_one_sel_a: assert property (@(posedge sys_clk) disable iff (reset)
		(chan_on_reg[3] && scaled_select_reg[3]) |=> chan_clk_tick[3] == $past(tick_s1))
		else $error("channel three not fed from scaled clock one");
	clock_a_sel_a: assert property (@(posedge sys_clk) disable iff (reset)
		(chan_on_reg[1] && !scaled_select_reg[1]) |=> chan_clk_tick[1] == $past(tick_a))
		else $error("channel one not fed from clock A");
	oe_follow_dir_a: assert property (@(posedge sys_clk) disable iff (reset)
		!chan_on_reg[2] |=> pin_oe_n[2] == !$past(port_direction_bits[2]))
		else $error("disabled pin ignored its direction bit");
	pin_gpio_a: assert property (@(posedge sys_clk) disable iff (reset)
		!started_reg[0] |=> pin_out[0] == $past(port_gpio_data[0]))
		else $error("wave reached pin before first channel tick");
	scaler_reload_a: assert property (@(posedge sys_clk) disable iff (reset)
		(reload0 && !wr_scal0) |=> scnt_zero_reg == $past(scale_zero_reg))
		else $error("scaler zero did not reload");
	scaler_down_a: assert property (@(posedge sys_clk) disable iff (reset)
		(tick_a && !reload0 && !wr_scal0)
			|=> scnt_zero_reg == 8'($past(scnt_zero_reg) - 8'h01))
		else $error("scaler zero did not count down");
	prescale_step_a: assert property (@(posedge sys_clk) disable iff (reset)
		(presc_run && !wr_presc) |=> presc_reg == 7'($past(presc_reg) + 7'h01))
		else $error("prescaler did not advance by one");
	load_inhibit_a: assert property (@(posedge sys_clk) disable iff (reset)
		(wr_scal0 && !load_ok && !tick_a) |=> $stable(scnt_zero_reg))
		else $error("inhibited scale write loaded scaler");
	scaled_half_one_a: assert property (@(posedge sys_clk) disable iff (reset)
		tick_s1 |=> !half_one_reg && !tick_s1)
		else $error("scaled clock one not halved");
endmodule : pwmcc_top
`default_nettype wire

// ### rtl/pwmcc_pkg.sv
// Package: register map, field layout, reset values and bus carrier of the PWM clock front end
package pwmcc_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_CLOCK_CTRL    = 8'h40;
	localparam logic [7:0] OFS_SEL_POL       = 8'h41;
	localparam logic [7:0] OFS_CHAN_ENABLE   = 8'h42;
	localparam logic [7:0] OFS_PRESCALE      = 8'h43;
	localparam logic [7:0] OFS_SCALE_ZERO    = 8'h44;
	localparam logic [7:0] OFS_SCNT_ZERO     = 8'h45;
	localparam logic [7:0] OFS_SCALE_ONE     = 8'h46;
	localparam logic [7:0] OFS_SCNT_ONE      = 8'h47;
	localparam logic [7:0] OFS_TEST_CTRL     = 8'h55;
	// ==========================================================
	// Field positions
	localparam int POS_JOIN_HIGH   = 7;
	localparam int POS_JOIN_LOW    = 6;
	localparam int POS_CLKA_LSB    = 3;
	localparam int POS_CLKB_LSB    = 0;
	localparam int POS_SEL_LSB     = 4;
	localparam int POS_POL_LSB     = 0;
	localparam int POS_LOAD_INHIB  = 5;
	localparam int NUM_CHAN        = 4;
	localparam int PRESC_WIDTH     = 7;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_BYTE      = 8'h00;
	localparam logic [6:0] RST_PRESC     = 7'h00;
	localparam logic [3:0] RST_NIBBLE    = 4'h0;
	localparam logic [2:0] RST_DIV       = 3'h0;
	// ==========================================================
	// Bus request carrier
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pwmcc_bus_s;
endpackage : pwmcc_pkg

// ### verif/tb_pwmcc_top.sv
// Self-checking bench for the PWM clock front end: registers, clock division, joins and pins
`timescale 1ns/100ps
`default_nettype none
module tb_pwmcc_top;
	import pwmcc_pkg::*;
	// ==========================================================
	// Signals, clock and design
	logic        sys_clk;
	logic        reset;
	pwmcc_bus_s  bus_req;
	logic [7:0]  rd_data;
	logic        special_mode_flag;
	logic [3:0]  port_direction_bits;
	logic [3:0]  port_gpio_data;
	logic [3:0]  chan_period_start;
	logic [3:0]  chan_duty_match;
	logic [3:0]  chan_clk_tick;
	logic        join_pair_low;
	logic        join_pair_high;
	logic [3:0]  pin_out;
	logic [3:0]  pin_oe_n;
	logic [7:0]  first_val;
	int          bad_count;
	int          tests_run;
	int          cnt [4];

	// Half period of 2 ns gives 250 MHz
	always #2 sys_clk = ~sys_clk;

	pwmcc_top dut (.sys_clk(sys_clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
		.special_mode_flag(special_mode_flag), .port_direction_bits(port_direction_bits),
		.port_gpio_data(port_gpio_data), .chan_period_start(chan_period_start),
		.chan_duty_match(chan_duty_match), .chan_clk_tick(chan_clk_tick),
		.join_pair_low(join_pair_low), .join_pair_high(join_pair_high),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n));

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One bus cycle; read data is sampled in the cycle after the strobe
	task automatic bus_op(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: ~w};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
		bus_req.rd <= 1'b0;
		#1;
	endtask : bus_op

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		bus_op(1'b1, a, d);
	endtask : wr_reg

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		bus_op(1'b0, a, 8'h00);
		check({8'h00, rd_data}, {8'h00, exp});
	endtask : rd_chk

	// Counts gated ticks per channel over 256 cycles after settling
	task automatic count_ticks();
		cnt = '{default: 0};
		repeat (8) @(posedge sys_clk);
		repeat (256) begin
			@(posedge sys_clk);
			#1;
			for (int i = 0; i < 4; i++) begin
				cnt[i] += int'(chan_clk_tick[i]);
			end
		end
	endtask : count_ticks

	// Pulses counter events, then lets the pin registers settle
	task automatic pulse(input logic [3:0] s, input logic [3:0] m);
		@(posedge sys_clk);
		chan_period_start <= s;
		chan_duty_match   <= m;
		@(posedge sys_clk);
		chan_period_start <= 4'h0;
		chan_duty_match   <= 4'h0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : pulse

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	// ==========================================================
	// Watchdog, well beyond the roughly 3000 cycles of the tests
	initial begin
		#200000;
		bad_count++;
		$display("watchdog expired");
		final_report();
	end

	// ==========================================================
	// Main sequence
	initial begin
		sys_clk = 1'b0;
		reset = 1'b1;
		bus_req = '0;
		special_mode_flag = 1'b0;
		port_direction_bits = 4'h0;
		port_gpio_data = 4'hA;
		chan_period_start = 4'h0;
		chan_duty_match = 4'h0;
		bad_count = 0;
		tests_run = 0;
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		// Reset values, unmapped place and read-only upper enable bits
		rd_chk(OFS_SEL_POL, RST_BYTE);
		rd_chk(OFS_CHAN_ENABLE, RST_BYTE);
		rd_chk(OFS_PRESCALE, RST_BYTE);
		rd_chk(OFS_SCALE_ZERO, RST_BYTE);
		rd_chk(8'h60, 8'h00);
		check({12'h000, pin_oe_n}, 16'h000F);
		wr_reg(OFS_CLOCK_CTRL, 8'h3F);
		wr_reg(OFS_SEL_POL, 8'hA5);
		rd_chk(OFS_SEL_POL, 8'hA5);
		wr_reg(OFS_CHAN_ENABLE, 8'hF0);
		rd_chk(OFS_CHAN_ENABLE, 8'h00);
		$display("test registers done");
		// Prescaler stopped, special-mode writes and scaler load inhibit
		rd_chk(OFS_PRESCALE, 8'h00);
		wr_reg(OFS_PRESCALE, 8'h05);
		rd_chk(OFS_PRESCALE, 8'h00);
		special_mode_flag <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wr_reg(OFS_PRESCALE, 8'h05);
		rd_chk(OFS_PRESCALE, 8'h05);
		wr_reg(OFS_PRESCALE, 8'hFF);
		rd_chk(OFS_PRESCALE, 8'h7F);
		wr_reg(OFS_PRESCALE, 8'h00);
		wr_reg(OFS_SCALE_ZERO, 8'h22);
		rd_chk(OFS_SCNT_ZERO, 8'h22);
		wr_reg(OFS_TEST_CTRL, 8'h20);
		wr_reg(OFS_SCALE_ZERO, 8'h11);
		rd_chk(OFS_SCNT_ZERO, 8'h22);
		rd_chk(OFS_SCALE_ZERO, 8'h11);
		wr_reg(OFS_TEST_CTRL, 8'h00);
		special_mode_flag <= 1'b0;
		repeat (4) @(posedge sys_clk);
		$display("test special mode done");
		// Every divide code on clock A (channel 0) and clock B (channel 2)
		wr_reg(OFS_SEL_POL, 8'h00);
		wr_reg(OFS_CHAN_ENABLE, 8'h05);
		for (int n = 0; n < 8; n++) begin
			wr_reg(OFS_CLOCK_CTRL, {2'b00, 3'(n), 3'(7 - n)});
			count_ticks();
			check(16'(cnt[0]), 16'(256 >> n));
			check(16'(cnt[2]), 16'(256 >> (7 - n)));
			check(16'(cnt[1] + cnt[3]), 16'h0000);
		end
		bus_op(1'b0, OFS_PRESCALE, 8'h00);
		first_val = rd_data;
		rd_chk(OFS_PRESCALE, {1'b0, 7'(first_val + 8'h02)});
		$display("test division done");
		// Scaled clocks: scale 3 gives 8 cycles, scale 1 gives 4 cycles
		wr_reg(OFS_SCALE_ZERO, 8'h03);
		wr_reg(OFS_SCALE_ONE, 8'h01);
		wr_reg(OFS_SEL_POL, 8'h50);
		wr_reg(OFS_CLOCK_CTRL, 8'h00);
		count_ticks();
		check(16'(cnt[0]), 16'd32);
		check(16'(cnt[2]), 16'd64);
		bus_op(1'b0, OFS_SCNT_ZERO, 8'h00);
		check({15'h0000, rd_data <= 8'h03}, 16'h0001);
		$display("test scaled clocks done");
		// Joined pairs take the lower-byte channel's select (channels 1 and 3) and free its pin
		wr_reg(OFS_SEL_POL, 8'hA0);
		wr_reg(OFS_CHAN_ENABLE, 8'h0F);
		wr_reg(OFS_CLOCK_CTRL, 8'hC0);
		count_ticks();
		check(16'(cnt[0]), 16'd32);
		check(16'(cnt[2]), 16'd64);
		check({14'h0000, join_pair_high, join_pair_low}, 16'h0003);
		check({12'h000, pin_oe_n}, 16'h000A);
		check({14'h0000, pin_out[3], pin_out[1]}, 16'h0003);
		$display("test joins done");
		// Both polarity settings, then pin handed back to the direction bit
		wr_reg(OFS_CLOCK_CTRL, 8'h00);
		wr_reg(OFS_SEL_POL, 8'h00);
		wr_reg(OFS_CHAN_ENABLE, 8'h01);
		pulse(4'h1, 4'h0);
		check({15'h0000, pin_out[0]}, 16'h0000);
		pulse(4'h0, 4'h1);
		check({15'h0000, pin_out[0]}, 16'h0001);
		wr_reg(OFS_SEL_POL, 8'h01);
		pulse(4'h1, 4'h0);
		check({15'h0000, pin_out[0]}, 16'h0001);
		pulse(4'h1, 4'h1);
		check({15'h0000, pin_out[0]}, 16'h0001);
		pulse(4'h0, 4'h1);
		check({15'h0000, pin_out[0]}, 16'h0000);
		check({12'h000, pin_oe_n}, 16'h000E);
		wr_reg(OFS_CHAN_ENABLE, 8'h00);
		repeat (2) @(posedge sys_clk);
		#1;
		check({12'h000, pin_oe_n}, 16'h000F);
		bus_op(1'b0, OFS_PRESCALE, 8'h00);
		first_val = rd_data;
		rd_chk(OFS_PRESCALE, first_val);
		@(posedge sys_clk);
		port_direction_bits <= 4'h1;
		repeat (2) @(posedge sys_clk);
		#1;
		check({12'h000, pin_oe_n}, 16'h000E);
		$display("test pins done");
		// Pin shows port data until the channel clock first ticks, then the wave
		special_mode_flag <= 1'b1;
		repeat (4) @(posedge sys_clk);
		wr_reg(OFS_PRESCALE, 8'h00);
		special_mode_flag <= 1'b0;
		repeat (4) @(posedge sys_clk);
		wr_reg(OFS_CLOCK_CTRL, 8'h38);
		wr_reg(OFS_CHAN_ENABLE, 8'h01);
		repeat (4) @(posedge sys_clk);
		#1;
		check({15'h0000, pin_out[0]}, 16'h0000);
		repeat (130) @(posedge sys_clk);
		#1;
		check({15'h0000, pin_out[0]}, 16'h0001);
		$display("test start delay done");
		// Reset in mid-run brings registers and pins back to idle
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		rd_chk(OFS_CLOCK_CTRL, RST_BYTE);
		rd_chk(OFS_CHAN_ENABLE, RST_BYTE);
		rd_chk(OFS_PRESCALE, RST_BYTE);
		check({8'h00, pin_oe_n, pin_out}, 16'h00EA);
		$display("test mid-run reset done");
		final_report();
	end
endmodule : tb_pwmcc_top
`default_nettype wire
